// ### verilog/raei_pkg.sv
package raei_pkg;

    // Internal clocks counted after the reset pin releases
    localparam int unsigned RST_RELEASE_CYCLES = 32;
    localparam int unsigned RST_CNT_W          = 6;
    localparam logic [5:0]  RST_CNT_RESET      = 6'h00;

    // Interrupt input count and trigger mode encoding
    localparam int unsigned IRQ_COUNT          = 2;
    localparam logic        IRQ_MODE_LEVEL     = 1'b0;
    localparam logic        IRQ_MODE_EDGE      = 1'b1;

    // Reset values
    localparam logic        BOOT_MODE_RESET    = 1'b0;
    localparam logic [1:0]  IRQ_SYNC_RESET     = 2'h3;

    // Reset sequencer states
    typedef enum logic [1:0] {
        RAEI_ST_HOLD,
        RAEI_ST_COUNT,
        RAEI_ST_RUN
    } raei_state_t;

endpackage : raei_pkg

// ### verilog/raei_irq_if.sv
`timescale 1ns/1ns
// Carries one interrupt channel between top and the channel logic
interface raei_irq_if;
    logic pin_n;
    logic mode;
    logic ack;
    logic req;

    modport top (output pin_n, output mode, output ack, input req);
    modport chan (input pin_n, input mode, input ack, output req);
endinterface : raei_irq_if

// ### verilog/raei_irq_chan.sv
`timescale 1ns/1ns
// One external interrupt channel: synchroniser, edge latch or level follow
module raei_irq_chan (
    // Clock and reset
    input  wire logic  i_ref_clk,
    input  wire logic  i_resetn,
    // Channel signals
    raei_irq_if.chan   irq
);

    logic [1:0] sync_reg;
    logic [1:0] sync_next;
    logic       prev_reg;
    logic       prev_next;
    logic       pend_reg;
    logic       pend_next;

    // Next state: edge detection reads the second stage and its one-cycle delayed copy prev_reg
    always_comb begin
        sync_next = {sync_reg[0], irq.pin_n};
        prev_next = sync_reg[1];
        pend_next = pend_reg;
        if (irq.ack) begin
            pend_next = 1'b0;
        end
        if (irq.mode == raei_pkg::IRQ_MODE_EDGE && prev_reg && !sync_reg[1]) begin
            pend_next = 1'b1;
        end
        if (irq.mode == raei_pkg::IRQ_MODE_LEVEL) begin
            pend_next = 1'b0;
        end
    end

    // Registers
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            sync_reg <= raei_pkg::IRQ_SYNC_RESET;
            prev_reg <= 1'b1;
            pend_reg <= 1'b0;
        end else begin
            sync_reg <= sync_next;
            prev_reg <= prev_next;
            pend_reg <= pend_next;
        end
    end

    assign irq.req = (irq.mode == raei_pkg::IRQ_MODE_LEVEL) ? !sync_reg[1] : pend_reg;

endmodule : raei_irq_chan

// ### verilog/raei_top.sv
`timescale 1ns/1ns
// Operation
// - First interrupt pin is synchronised; level or falling-edge selectable.
// - Second interrupt pin requests service on low level or falling edge.
// - While reset pin is low, all state except the boot strap synchroniser is held initialised.
// - On reset release, boot-mode pin level becomes the initial operating mode.
// - Internal reset ends synchronously after a fixed count of internal clocks.
// - Reset output pin always shows the internal reset state.
module raei_top (
    // Clock and hardware reset pin
    input  wire logic       i_ref_clk,
    input  wire logic       i_resetn,
    // Boot mode strap
    input  wire logic       i_boot_mode_select,
    // External interrupt pins, active low
    input  wire logic       i_ext_int_req_first_n,
    input  wire logic       i_ext_int_req_second_n,
    // Trigger mode per channel, 1 = falling edge
    input  wire logic [1:0] i_irq_mode,
    // Core acknowledge per channel, one-cycle pulse
    input  wire logic [1:0] i_irq_ack,
    // Requests to the core
    output logic [1:0]      o_irq_req,
    // Internal reset, active low, and reset state pin
    output logic            o_int_resetn,
    output logic            o_reset_state_out_n,
    // Captured operating mode
    output logic            o_boot_mode
);

    raei_pkg::raei_state_t                   state_reg;
    raei_pkg::raei_state_t                   state_next;
    logic [raei_pkg::RST_CNT_W-1:0]          cnt_reg;
    logic [raei_pkg::RST_CNT_W-1:0]          cnt_next;
    logic [1:0]                              boot_sync_reg;
    logic [1:0]                              boot_sync_next;
    logic                                    boot_reg;
    logic                                    boot_next;
    logic                                    int_rstn_reg;
    logic                                    int_rstn_next;
    logic [1:0]                              pin_n;

    localparam logic [raei_pkg::RST_CNT_W-1:0] CNT_LAST =
        raei_pkg::RST_CNT_W'(raei_pkg::RST_RELEASE_CYCLES - 1);

    assign pin_n = {i_ext_int_req_second_n, i_ext_int_req_first_n};

    // Sequencer next state
    always_comb begin
        state_next     = state_reg;
        cnt_next       = cnt_reg;
        boot_sync_next = {boot_sync_reg[0], i_boot_mode_select};
        boot_next      = boot_reg;
        int_rstn_next  = int_rstn_reg;
        unique case (state_reg)
            raei_pkg::RAEI_ST_HOLD: begin
                boot_next  = boot_sync_reg[1];
                state_next = raei_pkg::RAEI_ST_COUNT;
            end
            raei_pkg::RAEI_ST_COUNT: begin
                if (cnt_reg == CNT_LAST) begin
                    int_rstn_next = 1'b1;
                    state_next    = raei_pkg::RAEI_ST_RUN;
                end else begin
                    cnt_next = cnt_reg + 1'b1;
                end
            end
            raei_pkg::RAEI_ST_RUN: begin
                int_rstn_next = 1'b1;
            end
        endcase
    end

    // strap synchroniser runs through reset, so the level is settled at release
    always_ff @(posedge i_ref_clk) begin
        boot_sync_reg <= boot_sync_next;
    end

    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            state_reg     <= raei_pkg::RAEI_ST_HOLD;
            cnt_reg       <= raei_pkg::RST_CNT_RESET;
            boot_reg      <= raei_pkg::BOOT_MODE_RESET;
            int_rstn_reg  <= 1'b0;
        end else begin
            state_reg     <= state_next;
            cnt_reg       <= cnt_next;
            boot_reg      <= boot_next;
            int_rstn_reg  <= int_rstn_next;
        end
    end

    genvar g;
    generate
        for (g = 0; g < raei_pkg::IRQ_COUNT; g++) begin : g_irq
            raei_irq_if irq_bus ();
            assign irq_bus.pin_n = pin_n[g];
            assign irq_bus.mode  = i_irq_mode[g];
            assign irq_bus.ack   = i_irq_ack[g];
            assign o_irq_req[g]  = irq_bus.req & int_rstn_reg;
            raei_irq_chan u_chan (
                .i_ref_clk (i_ref_clk),
                .i_resetn  (int_rstn_reg),
                .irq       (irq_bus.chan)
            );
        end
    endgenerate

    assign o_int_resetn        = int_rstn_reg;
    assign o_reset_state_out_n = int_rstn_reg;
    assign o_boot_mode         = boot_reg;

endmodule : raei_top

// ### dv/raei_ext_dev.sv
`timescale 1ns/1ns
// Outside interrupt sources
module raei_ext_dev (
    input  wire logic [1:0] i_low,
    output logic      [1:0] o_pin_n
);
    // board reset drives the hardware pin only; no debug test reset here
    // Pins pulled low while a source requests
    assign o_pin_n = ~i_low;
endmodule : raei_ext_dev

// ### dv/raei_chk.sv
`timescale 1ns/1ns
module raei_chk (
    input wire logic       i_ref_clk,
    input wire logic       i_resetn,
    input wire logic       i_ext_int_req_first_n,
    input wire logic       i_ext_int_req_second_n,
    input wire logic [1:0] i_irq_mode,
    input wire logic [1:0] i_irq_ack,
    input wire logic [1:0] o_irq_req,
    input wire logic       o_int_resetn,
    input wire logic       o_reset_state_out_n,
    input wire logic       o_boot_mode
);
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (!i_resetn);
    logic [5:0] cnt_reg, cnt_next;
    // Cycles since pin release, saturating
    always_comb cnt_next = (cnt_reg == 6'h22) ? cnt_reg : cnt_reg + 6'h01;
    always_ff @(posedge i_ref_clk or negedge i_resetn)
        if (!i_resetn) cnt_reg <= 6'h00; else cnt_reg <= cnt_next;
    sequence seq_lvl0;
        (i_irq_mode[0] == raei_pkg::IRQ_MODE_LEVEL && o_int_resetn)[*3];
    endsequence
    sequence seq_fall0;
        ($fell(i_ext_int_req_first_n) && i_irq_mode[0] && o_int_resetn) ##1 (i_irq_mode[0] && !i_irq_ack[0])[*4];
    endsequence
    AST_RESET_STATE_OUT: assert property (o_reset_state_out_n == o_int_resetn) else $error("reset pin differs");
    AST_GATE: assert property (!o_int_resetn |-> o_irq_req == 2'h0) else $error("req in reset");
    AST_HOLD: assert property (cnt_reg < 6'h21 |-> !o_int_resetn) else $error("early release");
    AST_REL: assert property (cnt_reg > 6'h20 |-> o_int_resetn) else $error("late release");
    AST_BOOT: assert property (o_int_resetn |-> $stable(o_boot_mode)) else $error("boot moved");
    AST_LVL0: assert property (seq_lvl0 |-> o_irq_req[0] == !$past(i_ext_int_req_first_n, 2))
        else $error("level req first");
    AST_LVL1: assert property ((i_irq_mode[1] == raei_pkg::IRQ_MODE_LEVEL && o_int_resetn)[*3]
        |-> o_irq_req[1] == !$past(i_ext_int_req_second_n, 2)) else $error("level req second");
    AST_EDGE: assert property (seq_fall0 |-> o_irq_req[0]) else $error("edge not latched");
    AST_CLR: assert property (i_ext_int_req_first_n[*4] ##0 (i_irq_ack[0] && i_irq_mode[0]) |=> !o_irq_req[0])
        else $error("ack not clearing");
endmodule : raei_chk
bind raei_top raei_chk u_chk (.i_ref_clk, .i_resetn, .i_ext_int_req_first_n, .i_ext_int_req_second_n,
    .i_irq_mode, .i_irq_ack, .o_irq_req, .o_int_resetn, .o_reset_state_out_n, .o_boot_mode);

// ### dv/test_reset_and_ext_irq_inputs.sv
`timescale 1ns/1ns
module test_reset_and_ext_irq_inputs;
    logic       clk, rstn, boot, ir, ro, bm;
    logic [1:0] low, pin_n, mode, ack, req;
    int         n_errors, samples_checked, seed, n, k;
    raei_ext_dev u_dev (.i_low(low), .o_pin_n(pin_n));
    raei_top dut (.i_ref_clk(clk), .i_resetn(rstn), .i_boot_mode_select(boot),
        .i_ext_int_req_first_n(pin_n[0]), .i_ext_int_req_second_n(pin_n[1]), .i_irq_mode(mode),
        .i_irq_ack(ack), .o_irq_req(req), .o_int_resetn(ir), .o_reset_state_out_n(ro), .o_boot_mode(bm));
    // Clock
    initial begin
        clk = 0;
        forever #5 clk = ~clk;
    end
    task chk(input string s, input logic [7:0] e, input logic [7:0] g);
        samples_checked++;
        if (g !== e) begin
            n_errors++;
            $display("CHECK FAILED %s exp %0h got %0h", s, e, g);
        end
    endtask : chk
    task w(input int c);
        repeat (c) @(negedge clk);
    endtask : w
    task end_sim;
        $display("checks %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : end_sim
    // Release reset, time the internal release
    task rel(input logic b);
        boot = b;
        w(2);
        rstn = 1;
        n = 0;
        while (ir !== 1'b1 && n < 99) begin
            w(1);
            n++;
        end
        chk("release", 8'h21, n[7:0]);
        chk("reset_state_out", 8'h01, {7'h00, ro});
        chk("boot", {7'h00, b}, {7'h00, bm});
        $display("reset test done");
    endtask : rel
    initial begin
        seed = 53708;
        rstn = 0; boot = 0; low = 0; mode = 0; ack = 0;
        w(1);
        chk("in_reset", 8'h00, {4'h0, req, ir, ro});
        rel(1'b1);
        // Each channel in level then edge mode
        for (int ch = 0; ch < 2; ch++) begin
            for (int m = 0; m < 2; m++) begin
                mode[ch] = m[0];
                low[ch] = 1;
                w(2);
                chk("req_early", {7'h00, !m[0]}, {7'h00, req[ch]});
                w(1);
                chk("req_set", 8'h01, {7'h00, req[ch]});
                k = 1 + ($random(seed) & 7);
                low[ch] = 0;
                w(k + 3);
                chk("req_held", {7'h00, m[0]}, {7'h00, req[ch]});
                ack[ch] = 1;
                w(1);
                ack[ch] = 0;
                chk("req_clear", 8'h00, {7'h00, req[ch]});
            end
        end
        // Reset again with requests standing
        mode = 2'h0;
        low = 2'h3;
        w(3);
        rstn = 0;
        #1;
        chk("mid_reset", 8'h00, {4'h0, req, ir, ro});
        low = 0;
        k = $random(seed);
        rel(k[0]);
        $display("irq test done");
        end_sim;
    end
    // Watchdog
    initial begin
        #20000;
        n_errors++;
        end_sim;
    end
endmodule : test_reset_and_ext_irq_inputs
